// ==== src/tac_pkg.sv ====
package tac_pkg;
	// Register map
	localparam logic [7:0] OFS_IRQ_CTRL     = 8'h0b;
	localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_COUNT_LO     = 8'h0e;
	localparam logic [7:0] OFS_COUNT_HI     = 8'h0f;
	localparam logic [7:0] OFS_CNT_CTRL     = 8'h10;
	localparam logic [7:0] OFS_PERIPH_IE    = 8'h8c;
	// Field positions
	localparam int unsigned BIT_GIE    = 7;
	localparam int unsigned BIT_PERIPHERAL_IRQ_ENABLE   = 6;
	localparam int unsigned BIT_OVF    = 0;
	localparam int unsigned BIT_OVF_IE = 0;
	// Reset values and masks
	localparam logic [7:0]  RST_IRQ_CTRL   = 8'h00;
	localparam logic [7:0]  RST_CNT_CTRL   = 8'h00;
	localparam logic [7:0]  CTRL_IMPL_MASK = 8'h7f;
	localparam logic [7:0]  IRQ_KEEP_MASK  = 8'h01;
	localparam logic [15:0] RST_COUNT      = 16'h0000;
	localparam logic [15:0] COUNT_MAX      = 16'hffff;
	// Pin sampling
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned PIN_EXT     = 0;
	localparam int unsigned PIN_GATE    = 1;
	localparam int unsigned PIN_COUNT   = 2;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;

	typedef struct packed {
		logic       unused;
		logic       gate_enable;
		logic [1:0] prescale_select;
		logic       lp_osc_enable;
		logic       sync_bypass;
		logic       count_source_select;
		logic       counter_run;
	} tac_cnt_ctrl_t;
endpackage

// ==== src/tac_async_counter.sv ====
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Function
// - Bypass bit lets the sampled external clock count in sleep
// - Unsynced counting continues in sleep, wakes
// - Byte reads of running counter are stable
// - Oscillator enable bit starts low-power oscillator
// - Oscillator usable only with internal system clock
// - Oscillator enabled forces pins input, reads zero
// - Sleep counting only unsynced external source
// - Overflow wakes if run, enable, peripheral enable
// - Global enable also set vectors to handler
// - Count bytes unknown at power-on, kept otherwise
// - Control clears seven bits, top reads zero
// - Count wraps all ones to zero, sets flag
// - Bypass ignored with internal instruction clock
// - Count byte write clears hidden prescaler
module tac_async_counter #(
	parameter int unsigned ADDR_W = 8
) (
	// Clock and resets
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              sys_rst_b,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [7:0]        rd_data_q,
	// Pins
	input  wire logic              external_count_clock_pin,
	input  wire logic              gate_n_pin,
	// Core status
	input  wire logic              cpu_sleep,
	input  wire logic              sys_clk_intosc,
	// Outputs
	output logic                   lp_osc_run_q,
	output logic                   osc_pin_dir_force_q,
	output logic                   osc_pin_read_zero_q,
	output logic                   overflow_flag_q,
	output logic                   wake_q,
	output logic                   irq_vector_q
);
	initial begin
		if (ADDR_W < 8) begin
			$error("ADDR_W must be at least 8");
		end
	end

	tac_pkg::tac_cnt_ctrl_t ctrl_q;
	logic [7:0]  irq_ctrl_q;
	logic        ovf_ie_q;
	logic [15:0] cnt_q;
	logic [2:0]  pre_q;
	logic        ext_prev_q;
	logic        armed_q;
	logic [tac_pkg::PIN_COUNT-1:0] lvl_q;
	wire  [tac_pkg::PIN_COUNT-1:0] pins = {gate_n_pin, external_count_clock_pin};

	// Three-stage pin sampling; level moves only when stages two and three agree
	genvar g;
	generate
		for (g = 0; g < tac_pkg::PIN_COUNT; g++) begin : g_pin
			logic [tac_pkg::SYNC_STAGES-1:0] s_q;
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					s_q <= '0;
				end else begin
					s_q <= {s_q[tac_pkg::SYNC_STAGES-2:0], pins[g]};
				end
			end
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					lvl_q[g] <= 1'b0;
				end else if (s_q[1] == s_q[2]) begin
					lvl_q[g] <= s_q[2];
				end
			end
		end
	endgenerate

	// Address decode
	wire sel_irq   = addr == ADDR_W'(tac_pkg::OFS_IRQ_CTRL);
	wire sel_flags = addr == ADDR_W'(tac_pkg::OFS_PERIPH_FLAGS);
	wire sel_lo    = addr == ADDR_W'(tac_pkg::OFS_COUNT_LO);
	wire sel_hi    = addr == ADDR_W'(tac_pkg::OFS_COUNT_HI);
	wire sel_ctrl  = addr == ADDR_W'(tac_pkg::OFS_CNT_CTRL);
	wire sel_ie    = addr == ADDR_W'(tac_pkg::OFS_PERIPH_IE);
	wire wr_lo     = wr_stb & sel_lo;
	wire wr_hi     = wr_stb & sel_hi;
	wire cnt_wr    = wr_lo | wr_hi;

	// Count source and gating
	wire ext_sel   = ctrl_q.count_source_select;
	wire ext_lvl   = lvl_q[tac_pkg::PIN_EXT];
	wire gate_lvl  = lvl_q[tac_pkg::PIN_GATE];
	// A low level must be seen before the first counted rising edge
	wire ext_rise  = ext_lvl & ~ext_prev_q & armed_q;
	// Internal source is one tick per instruction clock; bypass bit is ignored
	wire src_edge  = ext_sel ? ext_rise : 1'b1;
	wire sleep_ok  = ~cpu_sleep | (ext_sel & ctrl_q.sync_bypass);
	wire gate_ok   = ~ctrl_q.gate_enable | ~gate_lvl;
	wire pre_tick  = ctrl_q.counter_run & gate_ok & sleep_ok & src_edge;
	wire [1:0] ps  = ctrl_q.prescale_select;
	wire [2:0] pre_mask = {ps == 2'b11, ps[1], ps != 2'b00};
	wire pre_done  = (pre_q & pre_mask) == pre_mask;
	wire cnt_tick  = pre_tick & pre_done;
	wire ovf       = cnt_tick & (cnt_q == tac_pkg::COUNT_MAX) & ~cnt_wr;
	wire irq_en    = ovf_ie_q & irq_ctrl_q[tac_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
	wire wake_cond = cpu_sleep & overflow_flag_q & irq_en & ctrl_q.counter_run;
	wire vec_cond  = overflow_flag_q & irq_en & irq_ctrl_q[tac_pkg::BIT_GIE];
	wire osc_on    = ctrl_q.lp_osc_enable & sys_clk_intosc;

	// Flag: a wrap in the same cycle as a clearing write still sets it
	wire flag_clr  = wr_stb & sel_flags & ~wr_data[tac_pkg::BIT_OVF];
	wire flag_wset = wr_stb & sel_flags & wr_data[tac_pkg::BIT_OVF];
	wire flag_d    = ovf | flag_wset | (overflow_flag_q & ~flag_clr);

	// Count next value; a write beats a coincident increment
	logic [15:0] cnt_d;
	always_comb begin
		cnt_d = cnt_q;
		if (wr_lo) begin
			cnt_d[7:0] = wr_data;
		end else if (wr_hi) begin
			cnt_d[15:8] = wr_data;
		end else if (cnt_tick) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	wire [2:0] pre_d = cnt_wr ? 3'h0 : (pre_tick ? (pre_done ? 3'h0 : pre_q + 3'h1) : pre_q);

	// Read mux; unmapped addresses read zero
	wire [7:0] rd_mux =
		sel_irq   ? irq_ctrl_q :
		sel_flags ? {7'h00, overflow_flag_q} :
		sel_lo    ? cnt_q[7:0] :
		sel_hi    ? cnt_q[15:8] :
		sel_ctrl  ? (ctrl_q & tac_pkg::CTRL_IMPL_MASK) :
		sel_ie    ? {7'h00, ovf_ie_q} : 8'h00;

	// Count bytes have no defined power-on value; zero is used, other resets keep them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= tac_pkg::RST_COUNT;
			pre_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			pre_q <= pre_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ext_prev_q <= 1'b0;
			armed_q    <= 1'b0;
		end else begin
			ext_prev_q <= ext_lvl;
			armed_q    <= (ctrl_q.counter_run & ext_sel) & (armed_q | ~ext_lvl);
		end
	end

	// Control survives the other resets; only power-on clears it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= tac_pkg::RST_CNT_CTRL;
		end else if (wr_stb & sel_ctrl) begin
			ctrl_q <= wr_data & tac_pkg::CTRL_IMPL_MASK;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ctrl_q      <= tac_pkg::RST_IRQ_CTRL;
			ovf_ie_q        <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else if (!sys_rst_b) begin
			irq_ctrl_q      <= irq_ctrl_q & tac_pkg::IRQ_KEEP_MASK;
			ovf_ie_q        <= 1'b0;
			overflow_flag_q <= 1'b0;
		end else begin
			if (wr_stb & sel_irq) begin
				irq_ctrl_q <= wr_data;
			end
			if (wr_stb & sel_ie) begin
				ovf_ie_q <= wr_data[tac_pkg::BIT_OVF_IE];
			end
			overflow_flag_q <= flag_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_q           <= 8'h00;
			lp_osc_run_q        <= 1'b0;
			osc_pin_dir_force_q <= 1'b0;
			osc_pin_read_zero_q <= 1'b0;
			wake_q              <= 1'b0;
			irq_vector_q        <= 1'b0;
		end else begin
			rd_data_q           <= rd_stb ? rd_mux : 8'h00;
			lp_osc_run_q        <= osc_on;
			osc_pin_dir_force_q <= ctrl_q.lp_osc_enable;
			osc_pin_read_zero_q <= ctrl_q.lp_osc_enable;
			wake_q              <= wake_cond;
			irq_vector_q        <= vec_cond;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Last count plus one, held in a flop so the internal-count check can compare against it
	logic [15:0] cnt_past1;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_past1 <= 16'h0001;
		end else begin
			cnt_past1 <= cnt_q + 16'h0001;
		end
	end

	chk_ovf_sets_flag: assert property (ovf && sys_rst_b |=> overflow_flag_q)
		else $error("overflow did not set flag");
	chk_wrap_to_zero: assert property (ovf |=> cnt_q == 16'h0000)
		else $error("counter did not wrap to zero");
	chk_write_clears_pre: assert property (cnt_wr |=> pre_q == 3'h0)
		else $error("prescaler not cleared by count write");
	chk_sleep_freeze: assert property (cpu_sleep && !(ext_sel && ctrl_q.sync_bypass) && !cnt_wr
		|=> $stable(cnt_q))
		else $error("counter moved in sleep without bypass");
	chk_wake_on_ovf: assert property (ovf && sys_rst_b && irq_en && cpu_sleep && ctrl_q.counter_run
		##1 cpu_sleep && ctrl_q.counter_run && irq_en && sys_rst_b |=> wake_q)
		else $error("no wake after overflow");
	chk_vector_gie: assert property (irq_vector_q == $past(vec_cond))
		else $error("vector request wrong");
	chk_osc_pins: assert property ($rose(ctrl_q.lp_osc_enable) |=> osc_pin_dir_force_q && osc_pin_read_zero_q)
		else $error("oscillator pins not forced");
	chk_ctrl_top_zero: assert property (rd_stb && sel_ctrl |=> rd_data_q[7] == 1'b0)
		else $error("control top bit not zero");
	chk_read_low: assert property (rd_stb && sel_lo |=> rd_data_q == $past(cnt_q[7:0]))
		else $error("low byte read mismatch");
	chk_internal_count: assert property (ctrl_q.counter_run && !ext_sel && !cpu_sleep && !ctrl_q.gate_enable
		&& ps == 2'b00 && !cnt_wr |=> cnt_q == cnt_past1)
		else $error("internal clock did not count");


	// Flag register port behaviour
	chk_flag_clear: assert property (wr_stb && sel_flags && !wr_data[tac_pkg::BIT_OVF] && !ovf && sys_rst_b
		|=> !overflow_flag_q)
		else $error("flag not cleared by write of zero");

	// Read data stands only in the cycle after a read strobe
	chk_read_idle: assert property (!rd_stb |=> rd_data_q == 8'h00)
		else $error("read data not zero outside read");

	chk_read_high: assert property (rd_stb && sel_hi |=> rd_data_q == $past(cnt_q[15:8]))
		else $error("high byte read mismatch");

	// Control keeps only the seven implemented bits
	chk_ctrl_write: assert property (wr_stb && sel_ctrl
		|=> ctrl_q == ($past(wr_data) & tac_pkg::CTRL_IMPL_MASK))
		else $error("control write not stored");

	// Oscillator runs only with the internal system clock
	chk_osc_run: assert property (lp_osc_run_q == $past(osc_on))
		else $error("oscillator run state wrong");

	// A non-power reset must leave control untouched
	chk_sysrst_ctrl: assert property (!sys_rst_b && !(wr_stb && sel_ctrl)
		|=> ctrl_q == $past(ctrl_q))
		else $error("control lost on other reset");

	chk_sysrst_flag: assert property (!sys_rst_b |=> !overflow_flag_q)
		else $error("flag kept through other reset");

	// A count write wins over a coincident increment
	chk_write_low: assert property (wr_lo |=> cnt_q[7:0] == $past(wr_data))
		else $error("low byte write lost");

	cov_ovf_sleep: cover property (ovf && cpu_sleep);
	cov_sync_ext: cover property (cnt_tick && ext_sel && !ctrl_q.sync_bypass);
	cov_wake: cover property ($rose(wake_q));
	cov_ext_tick: cover property (cnt_tick && ext_sel && ctrl_q.sync_bypass);
	cov_div8: cover property (cnt_tick && ps == 2'b11);
endmodule

// ==== bench/tac_lp_src_model.sv ====
`timescale 1ns/1ps
module tac_lp_src_model #(
	parameter int unsigned HALF_NS = 400
) (
	// Control
	input  wire logic en,
	// Pin
	output logic      pin
);
	// Held low while off, so a low level always comes before the first rise
	initial pin = 1'b0;
	always begin
		#(HALF_NS);
		pin = en ? ~pin : 1'b0;
	end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic       clk, rst_b, sys_rst_b, wr_stb, rd_stb, cpu_sleep, sys_clk_intosc, gate_n_pin, src_en, pin;
	logic       lp_osc_run_q, osc_pin_dir_force_q, osc_pin_read_zero_q, overflow_flag_q, wake_q, irq_vector_q;
	logic [7:0] addr, wr_data, rd_data_q, v, w;
	int         n_mismatch, total_checks, i;
	logic [7:0] zero_regs [5] = '{8'h10, 8'h0c, 8'h8c, 8'h0b, 8'h20};

	tac_async_counter dut (.clk(clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .external_count_clock_pin(pin),
		.gate_n_pin(gate_n_pin), .cpu_sleep(cpu_sleep), .sys_clk_intosc(sys_clk_intosc),
		.lp_osc_run_q(lp_osc_run_q), .osc_pin_dir_force_q(osc_pin_dir_force_q),
		.osc_pin_read_zero_q(osc_pin_read_zero_q), .overflow_flag_q(overflow_flag_q), .wake_q(wake_q),
		.irq_vector_q(irq_vector_q));
	tac_lp_src_model src (.en(src_en), .pin(pin));

	always #50 clk = ~clk;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe, so it is sampled just past that edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 d = rd_data_q;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		{clk, rst_b, wr_stb, rd_stb, cpu_sleep, gate_n_pin, src_en, addr, wr_data} = '0;
		{sys_rst_b, sys_clk_intosc} = 2'b11;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 5; i++) begin
			rd(zero_regs[i], v);
			chk(v, 8'h00);
		end
		wr(tac_pkg::OFS_CNT_CTRL, 8'hff);
		rd(tac_pkg::OFS_CNT_CTRL, v);
		chk(v, 8'h7f);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h08);
		idle(3);
		chk({5'h00, lp_osc_run_q, osc_pin_dir_force_q, osc_pin_read_zero_q}, 8'h07);
		sys_clk_intosc <= 1'b0;
		idle(3);
		chk({7'h00, lp_osc_run_q}, 8'h00);
		sys_clk_intosc <= 1'b1;
		// Loaded while stopped, so no write can collide with an increment
		wr(tac_pkg::OFS_COUNT_LO, 8'hfe);
		wr(tac_pkg::OFS_COUNT_HI, 8'hff);
		src_en <= 1'b1;
		idle(20);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h0f);
		for (i = 0; i < 200 && overflow_flag_q !== 1'b1; i++) idle(1);
		chk({7'h00, overflow_flag_q}, 8'h01);
		rd(tac_pkg::OFS_COUNT_HI, v);
		chk(v, 8'h00);
		cpu_sleep <= 1'b1;
		wr(tac_pkg::OFS_PERIPH_IE, 8'h01);
		wr(tac_pkg::OFS_IRQ_CTRL, 8'h40);
		idle(2);
		chk({6'h00, wake_q, irq_vector_q}, 8'h02);
		wr(tac_pkg::OFS_IRQ_CTRL, 8'hc0);
		idle(2);
		chk({6'h00, wake_q, irq_vector_q}, 8'h03);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h0e);
		idle(2);
		chk({6'h00, wake_q, irq_vector_q}, 8'h01);
		wr(tac_pkg::OFS_COUNT_LO, 8'h00);
		wr(tac_pkg::OFS_COUNT_HI, 8'h00);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h0b);
		idle(40);
		rd(tac_pkg::OFS_COUNT_LO, v);
		chk(v, 8'h00);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h0f);
		idle(40);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h0e);
		rd(tac_pkg::OFS_COUNT_LO, v);
		chk({7'h00, v >= 8'h04 && v <= 8'h06}, 8'h01);
		cpu_sleep <= 1'b0;
		src_en <= 1'b0;
		wr(tac_pkg::OFS_COUNT_LO, 8'h00);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h35);
		idle(80);
		wr(tac_pkg::OFS_CNT_CTRL, 8'h34);
		rd(tac_pkg::OFS_COUNT_LO, w);
		chk({7'h00, w >= 8'h09 && w <= 8'h0b}, 8'h01);
		sys_rst_b <= 1'b0;
		idle(1);
		sys_rst_b <= 1'b1;
		rd(tac_pkg::OFS_COUNT_LO, v);
		chk(v, w);
		rd(tac_pkg::OFS_CNT_CTRL, v);
		chk(v, 8'h34);
		chk({7'h00, overflow_flag_q}, 8'h00);
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		rd(tac_pkg::OFS_CNT_CTRL, v);
		chk(v, 8'h00);
		end_of_test();
	end

	// The sequence needs under 1000 cycles
	initial begin
		#300000;
		n_mismatch++;
		end_of_test();
	end
endmodule
